//--- link_enhance_pkg.sv
// Package with offsets, field layout and reset values for link enhancement registers
package link_enhance_pkg;
   localparam logic [7:0] link_feature_control_off = 8'hf4;
   localparam logic [7:0] subsystem_id_alias_off = 8'hf8;
   localparam logic [31:0] link_feature_control_rst = 32'h0000_1000;
   localparam logic [31:0] subsystem_id_alias_rst = 32'h0000_0000;
   localparam int mpeg_stamp_fix_pos = 10;
   localparam int dv_stamp_fix_pos = 8;
   localparam int priority_req_pos = 7;
   localparam int accel_notify_pos = 1;
   localparam int dev_alias_lsb = 16;
   localparam int ven_alias_lsb = 0;
   // Bits held in storage: 15, 13:12 (no assigned function, kept as stored) and 10, 8, 7, 1
   localparam logic [31:0] link_feature_control_wmask = 32'h0000_b582;
   localparam logic [7:0] cip_fmt_mpeg = 8'h20;
   localparam logic [7:0] cip_fmt_dv = 8'h00;

   typedef struct packed {
      logic mpeg_stamp_fix_on;
      logic dv_stamp_fix_on;
      logic priority_req_on;
      logic accel_notify_on;
   } link_feature_t;

   typedef struct packed {
      logic [15:0] subsystem_device_alias;
      logic [15:0] subsystem_vendor_alias;
   } subsystem_id_t;
endpackage

//--- link_enhance_subsys_regs.sv
// APB register bank for link enhancement control and subsystem access alias
//
// Function
// - Bits 11, 9 and 0 of link feature control read as zero.
// - Bits 5 to 2 of link feature control read as zero.
// - Bit 10 enables stamp fix for transmitted streams with format 20h.
// - Bit 8 enables stamp fix for transmitted streams with format 00h.
// - Bit 7 makes the link answer requests using priority arbitration.
// - Bit 6 is unassigned and read only.
// - Link feature control bits loadable at init from EEPROM enhancements field.
// - Bit 1 tells the PHY the link supports acceleration features.
// - A write to subsystem alias copies into subsystem identification registers.
// - Last written subsystem alias value reads back unchanged.
// - Device alias in bits 31:16, vendor alias in 15:0, both writable.
// - Subsystem alias register sits at F8h and resets to zero.
// - Link feature control sits at F4h and resets to 00001000h.
`timescale 1ns/1ps
`default_nettype none
module link_enhance_subsys_regs
   import link_enhance_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic reset_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire logic eeprom_load_i,
   input wire logic [31:0] eeprom_enh_i,
   input wire logic [7:0] tx_cip_fmt_i,
   output logic tx_stamp_fix_o,
   output logic priority_arb_on_o,
   output logic phy_accel_notify_o,
   output logic [31:0] subsystem_id_o,
   output logic subsystem_id_load_o
);
   logic [31:0] feat_reg;
   logic [31:0] feat_next;
   logic [31:0] alias_reg;
   logic [31:0] alias_next;
   logic [31:0] prdata_reg;
   logic [31:0] prdata_next;
   logic pslverr_reg;
   logic pready_reg;
   logic stamp_reg;
   logic prio_reg;
   logic accel_reg;
   logic id_load_reg;
   logic [31:0] id_reg;
   logic [7:0] fmt_s1_reg;
   logic [7:0] fmt_s2_reg;
   logic load_s1_reg;
   logic load_s2_reg;
   logic [31:0] eep_s1_reg;
   logic [31:0] eep_s2_reg;
   logic load_seen_reg;
   link_feature_t feat_view;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      hit = (a[7:2] == off[7:2]);
   endfunction

   wire setup_phase = psel_i && !penable_i;
   wire access_done = psel_i && penable_i && pready_reg;
   wire hit_feat = hit(paddr_i, link_feature_control_off);
   wire hit_alias = hit(paddr_i, subsystem_id_alias_off);
   wire wr_feat = access_done && pwrite_i && hit_feat;
   wire wr_alias = access_done && pwrite_i && hit_alias;
   wire unmapped = !(hit_feat || hit_alias);
   // EEPROM load on rising edge of synchronised strobe; bus write wins on tie
   wire eep_load = load_s2_reg && !load_seen_reg;
   wire [31:0] feat_wr = pwdata_i & link_feature_control_wmask;

   assign feat_view.mpeg_stamp_fix_on = feat_reg[mpeg_stamp_fix_pos];
   assign feat_view.dv_stamp_fix_on = feat_reg[dv_stamp_fix_pos];
   assign feat_view.priority_req_on = feat_reg[priority_req_pos];
   assign feat_view.accel_notify_on = feat_reg[accel_notify_pos];

   // Reserved positions never stored, so reads give zero
   assign feat_next = wr_feat ? feat_wr
      : eep_load ? (eep_s2_reg & link_feature_control_wmask)
      : feat_reg;
   assign alias_next = wr_alias ? pwdata_i : alias_reg;
   assign prdata_next = !(setup_phase && !pwrite_i) ? 32'h0000_0000
      : hit_feat ? feat_reg
      : hit_alias ? alias_reg
      : 32'h0000_0000;

   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         fmt_s1_reg <= 8'h00;
         fmt_s2_reg <= 8'h00;
         load_s1_reg <= 1'b0;
         load_s2_reg <= 1'b0;
         eep_s1_reg <= 32'h0000_0000;
         eep_s2_reg <= 32'h0000_0000;
         load_seen_reg <= 1'b0;
      end else begin
         fmt_s1_reg <= tx_cip_fmt_i;
         fmt_s2_reg <= fmt_s1_reg;
         load_s1_reg <= eeprom_load_i;
         load_s2_reg <= load_s1_reg;
         eep_s1_reg <= eeprom_enh_i;
         eep_s2_reg <= eep_s1_reg;
         load_seen_reg <= load_s2_reg;
      end
   end

   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         feat_reg <= link_feature_control_rst;
         alias_reg <= subsystem_id_alias_rst;
      end else begin
         feat_reg <= feat_next;
         alias_reg <= alias_next;
      end
   end

   // Ready one cycle into access phase: every transfer takes exactly two cycles
   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         pready_reg <= 1'b0;
         prdata_reg <= 32'h0000_0000;
         pslverr_reg <= 1'b0;
      end else begin
         pready_reg <= setup_phase;
         prdata_reg <= prdata_next;
         pslverr_reg <= setup_phase && unmapped;
      end
   end

   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         stamp_reg <= 1'b0;
         prio_reg <= 1'b0;
         accel_reg <= 1'b0;
         id_reg <= 32'h0000_0000;
         id_load_reg <= 1'b0;
      end else begin
         stamp_reg <= (feat_view.mpeg_stamp_fix_on && fmt_s2_reg == cip_fmt_mpeg)
            || (feat_view.dv_stamp_fix_on && fmt_s2_reg == cip_fmt_dv);
         prio_reg <= feat_view.priority_req_on;
         accel_reg <= feat_view.accel_notify_on;
         id_reg <= alias_next;
         id_load_reg <= wr_alias;
      end
   end

   assign prdata_o = prdata_reg;
   assign pready_o = pready_reg;
   assign pslverr_o = pslverr_reg;
   assign tx_stamp_fix_o = stamp_reg;
   assign priority_arb_on_o = prio_reg;
   assign phy_accel_notify_o = accel_reg;
   assign subsystem_id_o = id_reg;
   assign subsystem_id_load_o = id_load_reg;

   a_feat_reserved_zero: assert property (
      @(posedge sys_clk_i) disable iff (reset_i)
      (feat_reg & ~link_feature_control_wmask) == 32'h0000_0000)
      else $error("reserved feature bits nonzero");

   a_feat_low_reserved: assert property (
      @(posedge sys_clk_i) disable iff (reset_i)
      feat_reg[6:2] == 5'h00)
      else $error("feature bits 6:2 nonzero");

   a_mpeg_stamp_follow: assert property (
      @(posedge sys_clk_i) disable iff (reset_i)
      feat_reg[10] && fmt_s2_reg == 8'h20 |=> tx_stamp_fix_o)
      else $error("mpeg stamp fix missing");

   a_dv_stamp_follow: assert property (
      @(posedge sys_clk_i) disable iff (reset_i)
      !feat_reg[10] && fmt_s2_reg == 8'h00 |=> tx_stamp_fix_o == $past(feat_reg[8]))
      else $error("dv stamp fix wrong");

   a_prio_after_write: assert property (
      @(posedge sys_clk_i) disable iff (reset_i)
      wr_feat |=> ##1 priority_arb_on_o == $past(pwdata_i[7], 2))
      else $error("priority enable not applied");

   a_accel_after_write: assert property (
      @(posedge sys_clk_i) disable iff (reset_i)
      wr_feat |=> ##1 phy_accel_notify_o == $past(pwdata_i[1], 2))
      else $error("accel notify not applied");

   a_alias_mirror: assert property (
      @(posedge sys_clk_i) disable iff (reset_i)
      wr_alias |=> subsystem_id_load_o && subsystem_id_o == $past(pwdata_i))
      else $error("alias not mirrored");

   a_alias_readback: assert property (
      @(posedge sys_clk_i) disable iff (reset_i)
      setup_phase && !pwrite_i && hit_alias |=> prdata_o == $past(alias_reg))
      else $error("alias readback wrong");

   a_alias_stable: assert property (
      @(posedge sys_clk_i) disable iff (reset_i)
      !wr_alias |=> $stable(alias_reg))
      else $error("alias changed without write");

   a_ready_timing: assert property (
      @(posedge sys_clk_i) disable iff (reset_i)
      setup_phase |=> pready_o ##1 !pready_o)
      else $error("pready timing wrong");

   a_read_reserved_bits_zero: assert property (
      @(posedge sys_clk_i) disable iff (reset_i)
      setup_phase && !pwrite_i && hit_feat |=> !prdata_o[11] && !prdata_o[9] && !prdata_o[0])
      else $error("reserved feature bits read nonzero");

   a_read_low_zero: assert property (
      @(posedge sys_clk_i) disable iff (reset_i)
      setup_phase && !pwrite_i && hit_feat |=> prdata_o[5:2] == 4'h0)
      else $error("feature bits 5:2 read nonzero");

   a_bit6_unassigned: assert property (
      @(posedge sys_clk_i) disable iff (reset_i)
      feat_reg[6] == 1'b0)
      else $error("feature bit 6 stored");

   a_read_bit6_zero: assert property (
      @(posedge sys_clk_i) disable iff (reset_i)
      setup_phase && !pwrite_i && hit_feat |=> !prdata_o[6])
      else $error("feature bit 6 read nonzero");

   a_feat_upper_zero: assert property (
      @(posedge sys_clk_i) disable iff (reset_i)
      feat_reg[31:16] == 16'h0000)
      else $error("feature upper half nonzero");

   a_feat_readback: assert property (
      @(posedge sys_clk_i) disable iff (reset_i)
      setup_phase && !pwrite_i && hit_feat |=> prdata_o == $past(feat_reg))
      else $error("feature readback wrong");

   a_feat_write_lands: assert property (
      @(posedge sys_clk_i) disable iff (reset_i)
      wr_feat |=> feat_reg == ($past(pwdata_i) & link_feature_control_wmask))
      else $error("feature write not stored");

   a_feat_hold: assert property (
      @(posedge sys_clk_i) disable iff (reset_i)
      !wr_feat && !eep_load |=> $stable(feat_reg))
      else $error("feature changed without cause");

   a_eep_load_apply: assert property (
      @(posedge sys_clk_i) disable iff (reset_i)
      eep_load && !wr_feat |=> feat_reg == ($past(eep_s2_reg) & link_feature_control_wmask))
      else $error("eeprom load not applied");

   a_eep_edge_once: assert property (
      @(posedge sys_clk_i) disable iff (reset_i)
      eep_load |=> !eep_load)
      else $error("eeprom load repeated");

   a_stamp_none_off: assert property (
      @(posedge sys_clk_i) disable iff (reset_i)
      !feat_reg[10] && !feat_reg[8] |=> !tx_stamp_fix_o)
      else $error("stamp fix without enable");

   a_mpeg_needs_bit: assert property (
      @(posedge sys_clk_i) disable iff (reset_i)
      !feat_reg[10] && fmt_s2_reg == 8'h20 |=> !tx_stamp_fix_o)
      else $error("mpeg stamp fix while disabled");

   a_dv_needs_bit: assert property (
      @(posedge sys_clk_i) disable iff (reset_i)
      !feat_reg[8] && fmt_s2_reg == 8'h00 |=> !tx_stamp_fix_o)
      else $error("dv stamp fix while disabled");

   a_stamp_other_fmt: assert property (
      @(posedge sys_clk_i) disable iff (reset_i)
      fmt_s2_reg != 8'h20 && fmt_s2_reg != 8'h00 |=> !tx_stamp_fix_o)
      else $error("stamp fix for other format");

   a_prio_follow: assert property (
      @(posedge sys_clk_i) disable iff (reset_i)
      1'b1 |=> priority_arb_on_o == $past(feat_reg[7]))
      else $error("priority output off its bit");

   a_accel_follow: assert property (
      @(posedge sys_clk_i) disable iff (reset_i)
      1'b1 |=> phy_accel_notify_o == $past(feat_reg[1]))
      else $error("accel output off its bit");

   a_alias_write_lands: assert property (
      @(posedge sys_clk_i) disable iff (reset_i)
      wr_alias |=> alias_reg == $past(pwdata_i))
      else $error("alias write not stored");

   a_dev_alias_field: assert property (
      @(posedge sys_clk_i) disable iff (reset_i)
      wr_alias |=> subsystem_id_o[31:16] == $past(pwdata_i[31:16]))
      else $error("device alias field wrong");

   a_ven_alias_field: assert property (
      @(posedge sys_clk_i) disable iff (reset_i)
      wr_alias |=> subsystem_id_o[15:0] == $past(pwdata_i[15:0]))
      else $error("vendor alias field wrong");

   a_id_load_pulse: assert property (
      @(posedge sys_clk_i) disable iff (reset_i)
      subsystem_id_load_o |=> !subsystem_id_load_o)
      else $error("id load longer than one cycle");

   a_id_load_cause: assert property (
      @(posedge sys_clk_i) disable iff (reset_i)
      subsystem_id_load_o |-> $past(wr_alias))
      else $error("id load without alias write");

   a_id_tracks_alias: assert property (
      @(posedge sys_clk_i) disable iff (reset_i)
      subsystem_id_o == alias_reg)
      else $error("id differs from alias");

   a_unmapped_err: assert property (
      @(posedge sys_clk_i) disable iff (reset_i)
      setup_phase && unmapped |=> pslverr_o && prdata_o == 32'h0000_0000)
      else $error("unmapped access not refused");

   a_mapped_no_err: assert property (
      @(posedge sys_clk_i) disable iff (reset_i)
      setup_phase && !unmapped |=> !pslverr_o)
      else $error("mapped access refused");

   a_err_with_ready: assert property (
      @(posedge sys_clk_i) disable iff (reset_i)
      pslverr_o |-> pready_o)
      else $error("error without ready");

   a_idle_rdata_zero: assert property (
      @(posedge sys_clk_i) disable iff (reset_i)
      !pready_o |-> prdata_o == 32'h0000_0000)
      else $error("read data outside access");

   a_write_rdata_zero: assert property (
      @(posedge sys_clk_i) disable iff (reset_i)
      setup_phase && pwrite_i |=> prdata_o == 32'h0000_0000)
      else $error("read data during write");

   a_ready_after_setup: assert property (
      @(posedge sys_clk_i) disable iff (reset_i)
      pready_o |-> $past(setup_phase))
      else $error("ready without setup");

   a_unmapped_no_store: assert property (
      @(posedge sys_clk_i) disable iff (reset_i)
      setup_phase && unmapped |=> ##1 $stable(alias_reg))
      else $error("unmapped write stored");
endmodule
`default_nettype wire

//--- tb_link_enhance_subsys_regs.sv
// Self-checking bench for the link enhancement register bank
`timescale 1ns/1ps
`default_nettype none
module tb_link_enhance_subsys_regs;
   import link_enhance_pkg::*;
   logic sys_clk_i = 1'b0, reset_i = 1'b1, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
   logic eeprom_load_i = 1'b0, pready_o, pslverr_o, tx_stamp_fix_o, priority_arb_on_o;
   logic phy_accel_notify_o, subsystem_id_load_o;
   logic [7:0] paddr_i = 8'h00, tx_cip_fmt_i = 8'h00;
   logic [31:0] pwdata_i = 32'h0, eeprom_enh_i = 32'h0, prdata_o, subsystem_id_o, v;
   logic [32:0] notes[$];
   int bad_count = 0, cmp_count = 0;
   // Stamp cases: feature value, stream format, expected fix
   logic [31:0] fv [6] = '{32'h400, 32'h400, 32'h100, 32'h100, 32'h500, 32'h0};
   logic [7:0] ff [6] = '{8'h20, 8'h00, 8'h00, 8'h20, 8'h21, 8'h20};
   logic fe [6] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
   link_enhance_subsys_regs u_link_enhance_subsys_regs (.sys_clk_i(sys_clk_i),
      .reset_i(reset_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
      .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
      .pslverr_o(pslverr_o), .eeprom_load_i(eeprom_load_i), .eeprom_enh_i(eeprom_enh_i),
      .tx_cip_fmt_i(tx_cip_fmt_i), .tx_stamp_fix_o(tx_stamp_fix_o),
      .priority_arb_on_o(priority_arb_on_o), .phy_accel_notify_o(phy_accel_notify_o),
      .subsystem_id_o(subsystem_id_o), .subsystem_id_load_o(subsystem_id_load_o));
   task automatic check(input string what, input logic [32:0] seen, input logic [32:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic print_verdict;
      $display("compares %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // Reads leave a note; request held until pready is seen high
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      input logic [32:0] exp);
      if (!wr) notes.push_back(exp);
      @(posedge sys_clk_i);
      psel_i <= 1'b1;
      pwrite_i <= wr;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge sys_clk_i);
      penable_i <= 1'b1;
      do @(posedge sys_clk_i); while (pready_o !== 1'b1);
      psel_i <= 1'b0;
      penable_i <= 1'b0;
   endtask
   always @(posedge sys_clk_i) begin : monitor
      logic [32:0] n;
      if (psel_i && penable_i && !pwrite_i && pready_o === 1'b1) begin
         n = notes.pop_front();
         check("read", {pslverr_o, prdata_o}, n);
      end
   end
   initial begin
      forever #4 sys_clk_i = ~sys_clk_i;
   end
   initial begin
      repeat (5000) @(posedge sys_clk_i);
      bad_count++;
      print_verdict();
   end
   initial begin
      v = $urandom(32'h686c);
      repeat (20) @(posedge sys_clk_i);
      reset_i <= 1'b0;
      @(posedge sys_clk_i);
      apb(1'b0, link_feature_control_off, 0, {1'b0, link_feature_control_rst});
      apb(1'b0, subsystem_id_alias_off, 0, {1'b0, subsystem_id_alias_rst});
      check("accel", phy_accel_notify_o, 0);
      $display("test reset done");
      apb(1'b1, link_feature_control_off, 32'hffff_ffff, 0);
      apb(1'b0, link_feature_control_off, 0, 33'h0_0000_b582);
      repeat (3) @(posedge sys_clk_i);
      check("prio", priority_arb_on_o, 1);
      check("accel", phy_accel_notify_o, 1);
      apb(1'b1, link_feature_control_off, 32'h0000_0002, 0);
      repeat (3) @(posedge sys_clk_i);
      check("prio", priority_arb_on_o, 0);
      check("accel", phy_accel_notify_o, 1);
      $display("test feature bits done");
      repeat (4) begin
         v = $urandom();
         apb(1'b1, subsystem_id_alias_off, v, 0);
         #1 check("load", subsystem_id_load_o, 1);
         @(posedge sys_clk_i);
         #1 check("load", subsystem_id_load_o, 0);
         check("id", subsystem_id_o, {1'b0, v});
         apb(1'b0, subsystem_id_alias_off, 0, {1'b0, v});
      end
      $display("test alias done");
      foreach (fv[i]) begin
         apb(1'b1, link_feature_control_off, fv[i], 0);
         tx_cip_fmt_i <= ff[i];
         repeat (6) @(posedge sys_clk_i);
         #1 check("stamp", tx_stamp_fix_o, fe[i]);
      end
      $display("test stamp done");
      // Unmapped place: refused, nothing stored
      apb(1'b1, 8'hf0, 32'hffff_ffff, 0);
      apb(1'b0, 8'hf0, 0, 33'h1_0000_0000);
      apb(1'b0, subsystem_id_alias_off, 0, {1'b0, v});
      $display("test unmapped done");
      v = $urandom();
      eeprom_enh_i <= v;
      @(posedge sys_clk_i);
      eeprom_load_i <= 1'b1;
      repeat (6) @(posedge sys_clk_i);
      eeprom_load_i <= 1'b0;
      apb(1'b0, link_feature_control_off, 0, {1'b0, v & link_feature_control_wmask});
      repeat (2) @(posedge sys_clk_i);
      $display("test eeprom done");
      print_verdict();
   end
endmodule
`default_nettype wire
